// File: src/aad_regs.vh
`ifndef AAD_REGS_VH
`define AAD_REGS_VH
// =============================================================
// Opcode patterns (upper byte for literal forms, upper six bits for register forms).
`define AAD_OP_ADD_LIT      8'h0F
`define AAD_OP_AND_LIT      8'h0B
`define AAD_OP6_ADD_CARRY   6'h08
`define AAD_OP6_ADD_REG     6'h09
`define AAD_OP6_AND_REG     6'h05
// =============================================================
// Instruction word fields.
`define AAD_BIT_DEST        9
`define AAD_BIT_BANK        8
// =============================================================
// Fixed access window: low addresses map to bank 0, high ones to the top bank.
`define AAD_ACCESS_SPLIT    8'h80
`define AAD_BANK_LOW        4'h0
`define AAD_BANK_HIGH       4'hF
// =============================================================
// Phase codes of the four-phase instruction cycle.
`define AAD_PH_DECODE       2'h0
`define AAD_PH_READ         2'h1
`define AAD_PH_PROCESS      2'h2
`define AAD_PH_WRITE        2'h3
// =============================================================
// Reset values.
`define AAD_ACC_RESET       8'h00
`define AAD_FLAGS_RESET     5'h00
`endif

// File: src/aad_adder.v
`timescale 1ns/100ps
`default_nettype none
// =============================================================
// Eight-bit adder with carry in, giving carry, digit carry and overflow.
module aad_adder (
  input  wire [7:0] a_i,          // Accumulator operand.
  input  wire [7:0] b_i,          // Literal or register operand.
  input  wire       carry_i,      // Carry in.
  output wire [7:0] sum_o,        // Eight-bit sum.
  output wire       carry_o,      // Carry out of bit 7.
  output wire       digit_o,      // Carry out of bit 3.
  output wire       overflow_o    // Signed overflow.
);
  wire [4:0] low_sum;             // Low nibble with its carry.
  wire [8:0] full_sum;            // Whole sum with its carry.

  // The digit carry comes from a separate nibble add so no borrow of the full path is needed.
  assign low_sum    = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, carry_i};
  assign full_sum   = {1'b0, a_i} + {1'b0, b_i} + {8'h00, carry_i};
  assign sum_o      = full_sum[7:0];
  assign carry_o    = full_sum[8];
  assign digit_o    = low_sum[4];
  // Overflow when both operands share a sign that the sum does not.
  assign overflow_o = (a_i[7] == b_i[7]) && (full_sum[7] != a_i[7]);
endmodule // aad_adder
`default_nettype wire

// File: src/aad_datapath.v
// Behaviour
// - Upper byte 0000 1111 decodes add literal.
// - Add literal result goes to accumulator only.
// - Add with carry sums acc, register, carry.
// - Add with carry routes by destination bit.
// - Upper bits 0001 01 decode AND register.
// - AND register result routed by destination bit.
// - Bank bit picks access window or bank select.
// - AND register updates only negative and zero.
// - Add forms update all five arithmetic flags.
// - AND literal writes acc, zero and negative.
`timescale 1ns/100ps
`default_nettype none
`include "aad_regs.vh"

// =============================================================
// Accumulator add and AND datapath.
module aad_datapath (
  input  wire        clk_i,                 // Core clock, four edges per instruction.
  input  wire        reset_i,               // Asynchronous core reset, active high.
  input  wire        instr_valid_i,         // A new word is offered at the decode phase.
  input  wire [15:0] instr_i,               // Instruction word from fetch.
  input  wire [3:0]  bank_select_register_i, // Current bank select value.
  input  wire [7:0]  mem_rdata_i,           // Data memory read data, valid in the read phase.
  input  wire        carry_i,               // Current carry flag from status.
  output wire        instr_ready_o,         // High in the decode phase: word is taken.
  output reg  [11:0] mem_addr_o,            // Full data memory address.
  output reg         mem_rd_o,              // Register read strobe.
  output reg  [7:0]  mem_wdata_o,           // Register write data.
  output reg         mem_wr_o,              // Register write strobe.
  output reg  [7:0]  acc_o,                 // Accumulator.
  output reg         carry_flag_o,          // Carry flag.
  output reg         digit_carry_flag_o,    // Digit carry flag.
  output reg         zero_flag_o,           // Zero flag.
  output reg         overflow_flag_o,       // Overflow flag.
  output reg         negative_flag_o,       // Negative flag.
  output reg         flags_wr_o,            // One-cycle pulse when flags update.
  output reg         illegal_o,             // Pulse: word is not one of this group.
  output wire [1:0]  phase_o                // Current phase.
);

  // Operation codes held from decode.
  // OP_NONE doubles as the idle code, so an empty cycle needs no extra state bit.
  localparam OP_NONE   = 3'h0;
  localparam OP_ADDLIT = 3'h1;
  localparam OP_ANDLIT = 3'h2;
  localparam OP_ADDC   = 3'h3;
  localparam OP_ADDREG = 3'h4;
  localparam OP_ANDREG = 3'h5;

  // =============================================================
  // State held across the four phases.
  reg  [1:0]  phase;                        // Phase counter.
  reg  [2:0]  op;                           // Decoded operation.
  reg  [2:0]  next_op;                      // Decode result.
  reg  [7:0]  operand;                      // Literal or register value.
  reg         dest_reg;                     // Destination is the register.
  reg  [7:0]  result;                       // Result held for the write phase.
  reg         res_c;                        // Latched carry.
  reg         res_dc;                       // Latched digit carry.
  reg         res_ov;                       // Latched overflow.
  reg  [11:0] next_addr;                    // Address formed at decode.

  // Adder results and operation classes.
  wire [7:0]  sum;                          // Adder sum.
  wire        add_c;                        // Adder carry out.
  wire        add_dc;                       // Adder digit carry.
  wire        add_ov;                       // Adder overflow.
  wire        is_add;                       // Current op is an add form.
  wire        is_reg;                       // Current op reads a register.

  // =============================================================
  // Handshake and operation class decode.
  // The ready flag is combinational so that fetch sees it within the decode phase.
  assign phase_o       = phase;
  assign instr_ready_o = (phase == `AAD_PH_DECODE);
  assign is_add = (op == OP_ADDLIT) || (op == OP_ADDC) || (op == OP_ADDREG);
  assign is_reg = (op == OP_ADDC) || (op == OP_ADDREG) || (op == OP_ANDREG);

  // Only the add-with-carry form feeds the carry flag in.
  // carry into sum
  aad_adder u_adder (
    .a_i        (acc_o),
    .b_i        (operand),
    .carry_i    ((op == OP_ADDC) ? carry_i : 1'b0),
    .sum_o      (sum),
    .carry_o    (add_c),
    .digit_o    (add_dc),
    .overflow_o (add_ov)
  );

  // =============================================================
  // Decoder: classify the word and form the data address.
  always @* begin
    // A word outside the group leaves the code at OP_NONE.
    // The opcode patterns do not overlap, so the order of the tests is free.
    next_op = OP_NONE;
    if (instr_i[15:8] == `AAD_OP_ADD_LIT) begin
      next_op = OP_ADDLIT;
    end else if (instr_i[15:8] == `AAD_OP_AND_LIT) begin
      next_op = OP_ANDLIT;
    end else if (instr_i[15:10] == `AAD_OP6_ADD_CARRY) begin
      next_op = OP_ADDC;
    end else if (instr_i[15:10] == `AAD_OP6_ADD_REG) begin
      next_op = OP_ADDREG;
    end else if (instr_i[15:10] == `AAD_OP6_AND_REG) begin
      next_op = OP_ANDREG;
    end
    // The address is formed for every word; literal forms never use it.
    // bank addressing
    if (instr_i[`AAD_BIT_BANK]) begin
      next_addr = {bank_select_register_i, instr_i[7:0]};
    end else if (instr_i[7:0] < `AAD_ACCESS_SPLIT) begin
      next_addr = {`AAD_BANK_LOW, instr_i[7:0]};
    end else begin
      next_addr = {`AAD_BANK_HIGH, instr_i[7:0]};
    end
  end

  // =============================================================
  // Phase sequencer and datapath. The phase counter always runs, so a
  // missing word simply yields an idle instruction cycle.
  // Limitation: fetch must hold each word while instr_ready_o is high, since a
  // word offered in any other phase is never looked at.
  // four phase cycle
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      // Constants only, so the reset path needs no clock to settle.
      phase              <= `AAD_PH_DECODE;
      op                 <= OP_NONE;
      operand            <= 8'h00;
      dest_reg           <= 1'b0;
      result             <= 8'h00;
      res_c              <= 1'b0;
      res_dc             <= 1'b0;
      res_ov             <= 1'b0;
      mem_addr_o         <= 12'h000;
      mem_rd_o           <= 1'b0;
      mem_wdata_o        <= 8'h00;
      mem_wr_o           <= 1'b0;
      acc_o              <= `AAD_ACC_RESET;
      {carry_flag_o, digit_carry_flag_o, zero_flag_o,
       overflow_flag_o, negative_flag_o} <= `AAD_FLAGS_RESET;
      flags_wr_o         <= 1'b0;
      illegal_o          <= 1'b0;
    end else begin
      // Strobes default low so that each one lasts exactly one clock.
      phase      <= phase + 2'h1;
      mem_rd_o   <= 1'b0;
      mem_wr_o   <= 1'b0;
      flags_wr_o <= 1'b0;
      illegal_o  <= 1'b0;
      case (phase)
        `AAD_PH_DECODE: begin
          // Latch the word; a literal becomes the operand at once.
          op         <= instr_valid_i ? next_op : OP_NONE;
          // A refused word runs an empty cycle and writes nothing.
          illegal_o  <= instr_valid_i && (next_op == OP_NONE);
          operand    <= instr_i[7:0];
          dest_reg   <= instr_i[`AAD_BIT_DEST] && (instr_i[15:12] != 4'h0);
          mem_addr_o <= next_addr;
          mem_rd_o   <= instr_valid_i && ((next_op == OP_ADDC) ||
                        (next_op == OP_ADDREG) || (next_op == OP_ANDREG));
        end
        `AAD_PH_READ: begin
          // Register forms take the read data here.
          // Literal forms keep the operand taken at decode.
          if (is_reg) begin
            operand <= mem_rdata_i;
          end
        end
        `AAD_PH_PROCESS: begin
          // Compute the result and latch its flags.
          if (is_add) begin
            result <= sum;
          end else begin
            // Both logic forms share the AND path.
            result <= acc_o & operand;
          end
          // Adder flags are latched for every form; logic forms never apply them.
          res_c  <= add_c;
          res_dc <= add_dc;
          res_ov <= add_ov;
        end
        `AAD_PH_WRITE: begin
          // An empty or refused cycle leaves the register, accumulator and every flag untouched.
          if (op != OP_NONE) begin
            if (dest_reg) begin
              mem_wdata_o <= result;
              mem_wr_o    <= 1'b1;
            end else begin
              // Accumulator destination, always so for literal forms.
              acc_o <= result;
            end
            // Zero and negative follow the result for every form.
            zero_flag_o     <= (result == 8'h00);
            negative_flag_o <= result[7];
            flags_wr_o      <= 1'b1;
            if (is_add) begin
              carry_flag_o       <= res_c;
              digit_carry_flag_o <= res_dc;
              overflow_flag_o    <= res_ov;
            end
          end
        end
        default: begin
          // Unreachable with a two-bit phase; kept so the case is complete.
          op <= OP_NONE;
        end
      endcase
    end
  end
endmodule // aad_datapath
`default_nettype wire

// File: test/aad_datapath_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Timing and flag checks seen at the datapath ports.
module aad_datapath_checker (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [3:0]  bank_select_register_i,
  input wire logic        instr_ready_o,
  input wire logic [11:0] mem_addr_o,
  input wire logic        mem_rd_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic        mem_wr_o,
  input wire logic [7:0]  acc_o,
  input wire logic        carry_flag_o,
  input wire logic        digit_carry_flag_o,
  input wire logic        zero_flag_o,
  input wire logic        overflow_flag_o,
  input wire logic        negative_flag_o,
  input wire logic        flags_wr_o,
  input wire logic [1:0]  phase_o
);
  // All checks run on the core clock and rest while reset is high.
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ==========================================================
  // Helper: a valid logic-form word, so that the history below looks at one signal.
  wire and_word;                          // Valid AND literal or AND register word.
  assign and_word = instr_valid_i && (instr_i[15:10] == 6'h05 || instr_i[15:8] == 8'h0B);
  // ==========================================================
  // Properties.
  a_ready_phase: assert property (instr_ready_o == (phase_o == 2'h0))
    else $error("ready outside the decode phase");
  a_phase_step: assert property (!$past(reset_i) |-> phase_o == $past(phase_o) + 2'h1)
    else $error("phase did not advance by one");
  a_read_slot: assert property (mem_rd_o |-> phase_o == 2'h1 && $past(instr_valid_i))
    else $error("read strobe outside the read phase");
  a_write_slot: assert property (mem_wr_o |-> $past(mem_rd_o, 3) && flags_wr_o)
    else $error("register write without a read three cycles before");
  a_acc_cause: assert property (!$stable(acc_o) |-> flags_wr_o && !mem_wr_o)
    else $error("accumulator changed without an update");
  a_and_keeps: assert property (flags_wr_o && $past(and_word, 4) |->
    $stable(carry_flag_o) && $stable(digit_carry_flag_o) && $stable(overflow_flag_o))
    else $error("logic form touched carry, digit carry or overflow");
  a_flag_value: assert property (flags_wr_o |->
    zero_flag_o == ((mem_wr_o ? mem_wdata_o : acc_o) == 8'h00)
    && negative_flag_o == (mem_wr_o ? mem_wdata_o[7] : acc_o[7]))
    else $error("zero or negative flag disagrees with result");
  a_bank_map: assert property (mem_rd_o |->
    mem_addr_o == {($past(instr_i[8]) ? $past(bank_select_register_i) : {4{mem_addr_o[7]}}),
    $past(instr_i[7:0])})
    else $error("register address mapped to the wrong bank");
endmodule // aad_datapath_checker
bind aad_datapath aad_datapath_checker aad_datapath_checker_i (.clk_i(clk_i),
  .reset_i(reset_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
  .bank_select_register_i(bank_select_register_i), .instr_ready_o(instr_ready_o),
  .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wdata_o(mem_wdata_o),
  .mem_wr_o(mem_wr_o), .acc_o(acc_o), .carry_flag_o(carry_flag_o),
  .digit_carry_flag_o(digit_carry_flag_o), .zero_flag_o(zero_flag_o),
  .overflow_flag_o(overflow_flag_o), .negative_flag_o(negative_flag_o),
  .flags_wr_o(flags_wr_o), .phase_o(phase_o));
`default_nettype wire

// File: test/aad_datapath_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "aad_regs.vh"
// ==========================================================
// Self-checking bench: corner words, then random words back to back.
module aad_datapath_bench;
  logic clk_i = 1'b0, reset_i = 1'b1, instr_valid_i = 1'b0, carry_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic [3:0]  bank_select_register = 4'h0;
  logic [7:0]  rdata = 8'h00, m_acc = 8'h00;
  logic [4:0]  m_fl = 5'h00; // Model flags: carry, digit, zero, overflow, negative.
  wire  [11:0] mem_addr_o;
  wire  [7:0]  mem_wdata_o, acc_o;
  wire  [1:0]  phase_o;
  wire         rdy, mem_rd_o, mem_wr_o, c_o, dc_o, z_o, ov_o, n_o, flags_wr_o, illegal_o;
  integer      error_cnt = 0, checks_done = 0, cycles = 0, seed = 32'h63986780, i;
  logic [15:0] w;
  aad_datapath aad_datapath_i (.clk_i(clk_i), .reset_i(reset_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .bank_select_register_i(bank_select_register),
    .mem_rdata_i(rdata), .carry_i(carry_i), .instr_ready_o(rdy), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_wdata_o(mem_wdata_o), .mem_wr_o(mem_wr_o), .acc_o(acc_o),
    .carry_flag_o(c_o), .digit_carry_flag_o(dc_o), .zero_flag_o(z_o),
    .overflow_flag_o(ov_o), .negative_flag_o(n_o), .flags_wr_o(flags_wr_o),
    .illegal_o(illegal_o), .phase_o(phase_o));
  always #12.5 clk_i = ~clk_i;
  // A hang counts as a mismatch; the whole run needs about 270 cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Sum with carry in, returning carry, digit carry, overflow and the byte.
  function automatic logic [10:0] addf(input logic [7:0] a, b, input logic c);
    logic [8:0] s;
    s = a + b + c;
    addf = {s[8], (a[3:0] + b[3:0] + c) > 5'h0F, (a[7] == b[7]) && (s[7] != a[7]), s[7:0]};
  endfunction
  // One word offered in the decode phase, then checked one instruction cycle later.
  task automatic run(input logic [15:0] wd, input logic [7:0] rd, input logic [3:0] bs,
                     input logic ci);
    logic [7:0] b, r;
    logic [10:0] s;
    logic lit, rf, d, isand;
    lit = wd[15:8] == `AAD_OP_ADD_LIT || wd[15:8] == `AAD_OP_AND_LIT;
    rf = wd[15:10] == `AAD_OP6_ADD_CARRY || wd[15:10] == `AAD_OP6_ADD_REG
      || wd[15:10] == `AAD_OP6_AND_REG;
    isand = wd[15:8] == `AAD_OP_AND_LIT || wd[15:10] == `AAD_OP6_AND_REG;
    d = rf & wd[9];
    b = lit ? wd[7:0] : rd;
    s = addf(m_acc, b, ci & (wd[15:10] == `AAD_OP6_ADD_CARRY));
    r = isand ? (m_acc & b) : s[7:0];
    instr_i = wd;
    instr_valid_i = 1'b1;
    rdata = rd;
    bank_select_register = bs;
    carry_i = ci;
    @(posedge clk_i);
    #2 instr_valid_i = 1'b0;
    chk(mem_rd_o, rf);
    chk(illegal_o, !(lit | rf));
    if (rf) chk(mem_addr_o, {(wd[8] ? bs : {4{wd[7]}}), wd[7:0]});
    repeat (3) @(posedge clk_i);
    #2;
    if (lit | rf) begin
      m_fl[2] = (r == 8'h00);
      m_fl[0] = r[7];
      if (!isand) {m_fl[4], m_fl[3], m_fl[1]} = s[10:8];
      if (!d) m_acc = r;
    end
    chk(acc_o, m_acc);
    chk({c_o, dc_o, z_o, ov_o, n_o}, m_fl);
    chk({flags_wr_o, mem_wr_o}, {lit | rf, d});
    if (d) chk(mem_wdata_o, r);
  endtask
  task automatic conclude();
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Corner words first: carry chain into zero, then random words with every opcode.
  initial begin
    repeat (6) @(posedge clk_i);
    #2 reset_i = 1'b0;
    run(16'h0F10, 8'h00, 4'h0, 1'b0);
    run(16'h0F15, 8'h00, 4'h0, 1'b0);
    run(16'h0FDB, 8'h00, 4'h0, 1'b0);
    run(16'h0F7F, 8'h00, 4'h0, 1'b0);
    // A word that is not offered must give an empty cycle with nothing written.
    instr_i = 16'h0F01;
    repeat (4) @(posedge clk_i);
    #2 chk({flags_wr_o, mem_wr_o, acc_o}, {2'b00, m_acc});
    for (i = 0; i < 60; i++) begin
      w = $random(seed);
      case (i % 6)
        0: w[15:8] = `AAD_OP_ADD_LIT;
        1: w[15:8] = `AAD_OP_AND_LIT;
        2: w[15:10] = `AAD_OP6_ADD_CARRY;
        3: w[15:10] = `AAD_OP6_ADD_REG;
        4: w[15:10] = `AAD_OP6_AND_REG;
        default: w[15:8] = 8'hFF;
      endcase
      run(w, $random(seed), $random(seed), $random(seed));
    end
    conclude();
  end
endmodule // aad_datapath_bench
`default_nettype wire
